// [hw/usb_device_event_flags.sv]
/*
  Device-level event, error and control logic of a full/low-speed USB
  device controller, with an Avalon-MM slave for its registers.
  Assumes protocol events arrive as one-cycle pulses from link logic on
  the same clock; the two line-state levels come from pins.
*/
`timescale 1ns/1ps
module usb_device_event_flags
  import usb_evt_pkg::*;
#(
  parameter int unsigned N_EP           = usb_evt_pkg::NUM_EP,
  parameter int unsigned SUSPEND_CYCLES = usb_evt_pkg::SUSPEND_CYCLES,
  parameter int unsigned RESUME_CYCLES  = usb_evt_pkg::RESUME_CYCLES
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]      address_i,
  input  wire logic            read_i,
  input  wire logic            write_i,
  input  wire logic [31:0]     writedata_i,
  input  wire logic [3:0]      byteenable_i,
  output logic      [31:0]     readdata_o,
  output logic                 waitrequest_o,
  // Link-side events, same clock
  input  wire logic            usb_enable_i,
  input  wire logic            usb_clk_run_i,
  input  wire logic            sof_det_i,
  input  wire logic            sof_crc_bad_i,
  input  wire logic [10:0]     sof_frame_i,
  input  wire logic            bus_reset_end_i,
  input  wire logic            host_resume_end_i,
  input  wire logic [N_EP-1:0] ep_iso_i,
  input  wire logic [N_EP-1:0] in_empty_read_i,
  input  wire logic [N_EP-1:0] out_banks_full_i,
  input  wire logic [N_EP-1:0] out_crc_bad_i,
  input  wire logic [N_EP-1:0] out_too_long_i,
  input  wire logic [N_EP-1:0] out_rx_i,
  input  wire logic [N_EP-1:0] setup_rx_i,
  input  wire logic [N_EP-1:0] in_ready_i,
  input  wire logic [N_EP-1:0] stall_sent_i,
  input  wire logic [N_EP-1:0] nak_in_i,
  input  wire logic [N_EP-1:0] nak_out_i,
  // Pin levels
  input  wire logic            bus_idle_i,
  input  wire logic            line_active_i,
  // Outputs
  output logic                 usb_irq_o,
  output logic [N_EP-1:0]      endpoint_irq_o,
  output logic [N_EP-1:0]      out_drop_o,
  output logic [N_EP-1:0]      out_truncate_o,
  output logic                 cpu_reset_o,
  output logic                 dp_pullup_o,
  output logic                 dm_pullup_o,
  output logic                 resume_drive_o,
  output logic [6:0]           device_addr_value_o,
  output logic                 address_activate_o
);
  import usb_evt_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0]            ctrl_reg,    ctrl_next;
  logic [7:0]            dflag_reg,   dflag_next;
  logic [7:0]            den_reg,     den_next;
  logic [7:0]            addr_reg,    addr_next;
  logic [10:0]           frame_reg,   frame_next;
  logic                  fcrc_reg,    fcrc_next;
  logic [2:0]            ep_sel_reg,  ep_sel_next;
  logic [N_EP-1:0][7:0]  ep_flag_reg, ep_flag_next;
  logic [N_EP-1:0][7:0]  ep_en_reg,   ep_en_next;
  logic [31:0]           idle_cnt_reg, idle_cnt_next;
  logic [31:0]           rsm_cnt_reg,  rsm_cnt_next;
  logic                  suspended_reg, suspended_next;
  logic [1:0]            idle_sync_reg, active_sync_reg;
  logic                  active_prev_reg;
  logic                  wait_reg,     wait_next;
  logic [31:0]           rdata_reg,    rdata_next;
  logic                  irq_reg,      irq_next;
  logic [N_EP-1:0]       ep_irq_reg,   ep_irq_next;
  logic [N_EP-1:0]       drop_reg,     drop_next;
  logic [N_EP-1:0]       trunc_reg,    trunc_next;
  logic                  cpurst_reg,   cpurst_next;
  logic                  dp_reg,       dp_next;
  logic                  dm_reg,       dm_next;

  logic       wr_go;
  logic [7:0] wd;
  logic       ep_ok;

  // A write lands only on the edge where waitrequest is seen low
  assign wr_go = write_i && !wait_reg && byteenable_i[0];
  assign wd    = writedata_i[7:0];
  // Select values past the last endpoint reach no slice
  assign ep_ok = 32'(ep_sel_reg) < N_EP;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Only the second stage of each pair feeds logic, against metastability
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      idle_sync_reg   <= 2'h0;
      active_sync_reg <= 2'h0;
      active_prev_reg <= 1'b0;
    end else begin
      idle_sync_reg   <= {idle_sync_reg[0], bus_idle_i};
      active_sync_reg <= {active_sync_reg[0], line_active_i};
      active_prev_reg <= active_sync_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Endpoint flags, one slice per endpoint
  genvar g;
  generate
    for (g = 0; g < N_EP; g++) begin : g_ep
      logic [7:0] set;
      logic [7:0] clr;
      logic       sel_wr;
      always_comb begin
        // Events last one cycle; the enables only gate the interrupt
        set = 8'h00;
        set[EF_UNDER]  = ep_iso_i[g] && (in_empty_read_i[g] || out_banks_full_i[g]);
        set[EF_STALL]  = stall_sent_i[g] || (ep_iso_i[g] && out_crc_bad_i[g]);
        set[EF_RXOUT]  = out_rx_i[g] || out_too_long_i[g] ||
                         (ep_iso_i[g] && out_crc_bad_i[g]);
        set[EF_OVER]   = out_too_long_i[g];
        set[EF_TXIN]   = in_ready_i[g];
        set[EF_RXSTP]  = setup_rx_i[g];
        set[EF_NAKIN]  = nak_in_i[g];
        set[EF_NAKOUT] = nak_out_i[g];
        sel_wr = ep_ok && (32'(ep_sel_reg) == g);
        clr = (wr_go && sel_wr && address_i == OFS_EP_FLAGS) ? ~wd : 8'h00;
        // Set beats a simultaneous software clear
        ep_flag_next[g] = (ep_flag_reg[g] & ~clr) | set;
        ep_en_next[g]   = (wr_go && sel_wr && address_i == OFS_EP_EN) ? wd : ep_en_reg[g];
        ep_irq_next[g]  = |(ep_flag_next[g] & ep_en_next[g]);
        drop_next[g]    = ep_iso_i[g] && out_banks_full_i[g];
        trunc_next[g]   = out_too_long_i[g];
      end
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          ep_flag_reg[g] <= 8'h00;
          ep_en_reg[g]   <= 8'h00;
          ep_irq_reg[g]  <= 1'b0;
          drop_reg[g]    <= 1'b0;
          trunc_reg[g]   <= 1'b0;
        end else begin
          ep_flag_reg[g] <= ep_flag_next[g];
          ep_en_reg[g]   <= ep_en_next[g];
          ep_irq_reg[g]  <= ep_irq_next[g];
          drop_reg[g]    <= drop_next[g];
          trunc_reg[g]   <= trunc_next[g];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Device flags, control, counters and bus slave
  always_comb begin
    logic [7:0] dset;
    logic [7:0] dclr;
    logic       rsm_start;
    logic       rsm_done;
    logic       susp_hit;
    logic       wake_edge;
    dset      = 8'h00;
    dclr      = 8'h00;
    susp_hit  = 1'b0;
    wake_edge = 1'b0;
    rsm_start = 1'b0;
    rsm_done  = 1'b0;
    ctrl_next = ctrl_reg;
    den_next  = den_reg;
    addr_next = addr_reg;
    frame_next = frame_reg;
    fcrc_next = fcrc_reg;
    ep_sel_next    = ep_sel_reg;
    idle_cnt_next  = idle_cnt_reg;
    rsm_cnt_next   = rsm_cnt_reg;
    suspended_next = suspended_reg;

    // Bus inactivity timer; saturates so the flag fires once per idle spell
    susp_hit = 1'b0;
    // Any non-idle bus level rearms the timer and ends the suspended state
    if (!idle_sync_reg[1]) begin
      idle_cnt_next  = 32'h0000_0000;
      suspended_next = 1'b0;
    end else if (idle_cnt_reg < SUSPEND_CYCLES) begin
      idle_cnt_next = idle_cnt_reg + 32'h0000_0001;
      susp_hit      = (idle_cnt_reg == SUSPEND_CYCLES - 1);
      if (susp_hit) begin
        suspended_next = 1'b1;
      end
    end

    // Own resume drive must not count as a line wake-up
    wake_edge = active_sync_reg[1] && !active_prev_reg && suspended_reg &&
                !ctrl_reg[CTRL_REMOTE_WAKE];

    rsm_start = wr_go && address_i == OFS_CTRL && wd[CTRL_REMOTE_WAKE] &&
                dflag_reg[DF_SUSP] && !ctrl_reg[CTRL_REMOTE_WAKE];
    rsm_done  = ctrl_reg[CTRL_REMOTE_WAKE] && rsm_cnt_reg == RESUME_CYCLES - 1;
    // Drive length is fixed, counted from the write that accepted it
    if (ctrl_reg[CTRL_REMOTE_WAKE]) begin
      rsm_cnt_next = rsm_done ? 32'h0000_0000 : rsm_cnt_reg + 32'h0000_0001;
    end

    dset[DF_SUSP]  = susp_hit;
    dset[DF_SOF]   = sof_det_i;
    dset[DF_EORST] = bus_reset_end_i;
    dset[DF_WAKE]  = wake_edge;
    dset[DF_EORSM] = host_resume_end_i;
    dset[DF_UPRSM] = rsm_start || ctrl_reg[CTRL_REMOTE_WAKE];

    // Writes to read-only or unmapped offsets change nothing
    if (wr_go) begin
      unique case (address_i)
        OFS_CTRL: begin
          ctrl_next[CTRL_DETACH]    = wd[CTRL_DETACH];
          ctrl_next[CTRL_LOW_SPEED] = wd[CTRL_LOW_SPEED];
          ctrl_next[CTRL_CPU_RESET] = wd[CTRL_CPU_RESET];
        end
        OFS_DFLAGS: begin
          dclr = ~wd & DF_MASK;
          if (!usb_clk_run_i) begin
            dclr[DF_UPRSM] = 1'b0;
            dclr[DF_WAKE]  = 1'b0;
          end
        end
        OFS_DEN:     den_next = wd & DF_MASK;
        OFS_ADDR: begin
          addr_next[6:0] = wd[6:0];
          addr_next[ADDR_ACT] = addr_reg[ADDR_ACT] | wd[ADDR_ACT];
        end
        OFS_FRAME_HI: fcrc_next = fcrc_reg & wd[FRAME_CRC_BIT];
        OFS_EP_SEL:  ep_sel_next = wd[2:0];
        default: begin
        end
      endcase
    end

    if (rsm_start) begin
      ctrl_next[CTRL_REMOTE_WAKE] = 1'b1;
    end else if (rsm_done) begin
      ctrl_next[CTRL_REMOTE_WAKE] = 1'b0;
    end

    // Frame number is kept even from a corrupted start-of-frame
    if (sof_det_i) begin
      frame_next = sof_frame_i;
      if (sof_crc_bad_i) begin
        fcrc_next = 1'b1;
      end
    end

    // Hardware clears of the activate bit: disable or new bus reset
    if (!usb_enable_i || bus_reset_end_i) begin
      addr_next[ADDR_ACT] = 1'b0;
    end
    if (!usb_enable_i) begin
      ctrl_next[CTRL_CPU_RESET] = 1'b0;
    end

    dflag_next = ((dflag_reg & ~dclr) | dset) & DF_MASK;
    // Frame CRC error stays out of the device interrupt
    irq_next   = |(dflag_next & den_next);
    // CPU reset is a one-cycle pulse; the control bit survives it
    cpurst_next = bus_reset_end_i && ctrl_reg[CTRL_CPU_RESET];
    // Pull-ups follow the next control value, so bus_connect acts with the write
    dp_next = usb_enable_i && !ctrl_next[CTRL_DETACH] && !ctrl_next[CTRL_LOW_SPEED];
    dm_next = usb_enable_i && !ctrl_next[CTRL_DETACH] && ctrl_next[CTRL_LOW_SPEED];

    // One wait cycle per access; read data captured on the first edge
    wait_next  = !((read_i || write_i) && wait_reg);
    rdata_next = rdata_reg;
    if (read_i && wait_reg) begin
      rdata_next = 32'h0000_0000;
      // Reserved bits and write-only positions read as zero
      unique case (address_i)
        OFS_CTRL:     rdata_next[7:0] = ctrl_reg & 8'h0F;
        OFS_DFLAGS:   rdata_next[7:0] = dflag_reg;
        OFS_DEN:      rdata_next[7:0] = den_reg;
        OFS_ADDR:     rdata_next[7:0] = addr_reg;
        OFS_FRAME_HI: rdata_next[7:0] = {3'h0, fcrc_reg, 1'b0, frame_reg[10:8]};
        OFS_FRAME_LO: rdata_next[7:0] = frame_reg[7:0];
        OFS_EP_SEL:   rdata_next[7:0] = {5'h00, ep_sel_reg};
        OFS_EP_FLAGS: rdata_next[7:0] = ep_ok ? ep_flag_reg[ep_sel_reg] : 8'h00;
        OFS_EP_EN:    rdata_next[7:0] = ep_ok ? ep_en_reg[ep_sel_reg] : 8'h00;
        default:      rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg      <= CTRL_RESET;
      dflag_reg     <= 8'h00;
      den_reg       <= DEN_RESET;
      addr_reg      <= 8'h00;
      frame_reg     <= 11'h000;
      fcrc_reg      <= 1'b0;
      ep_sel_reg    <= 3'h0;
      idle_cnt_reg  <= 32'h0000_0000;
      rsm_cnt_reg   <= 32'h0000_0000;
      suspended_reg <= 1'b0;
      wait_reg      <= 1'b1;
      rdata_reg     <= 32'h0000_0000;
      irq_reg       <= 1'b0;
      cpurst_reg    <= 1'b0;
      dp_reg        <= 1'b0;
      dm_reg        <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      dflag_reg     <= dflag_next;
      den_reg       <= den_next;
      addr_reg      <= addr_next;
      frame_reg     <= frame_next;
      fcrc_reg      <= fcrc_next;
      ep_sel_reg    <= ep_sel_next;
      idle_cnt_reg  <= idle_cnt_next;
      rsm_cnt_reg   <= rsm_cnt_next;
      suspended_reg <= suspended_next;
      wait_reg      <= wait_next;
      rdata_reg     <= rdata_next;
      irq_reg       <= irq_next;
      cpurst_reg    <= cpurst_next;
      dp_reg        <= dp_next;
      dm_reg        <= dm_next;
    end
  end

  // Every output is a register or a register bit
  assign readdata_o          = rdata_reg;
  assign waitrequest_o       = wait_reg;
  assign usb_irq_o           = irq_reg;
  assign endpoint_irq_o      = ep_irq_reg;
  assign out_drop_o          = drop_reg;
  assign out_truncate_o      = trunc_reg;
  assign cpu_reset_o         = cpurst_reg;
  assign dp_pullup_o         = dp_reg;
  assign dm_pullup_o         = dm_reg;
  assign resume_drive_o      = ctrl_reg[CTRL_REMOTE_WAKE];
  assign device_addr_value_o = addr_reg[6:0];
  assign address_activate_o  = addr_reg[ADDR_ACT];
endmodule

// [hw/usb_evt_pkg.sv]
/*
  Constants for the USB device event and flag block: register byte
  offsets, bit positions, reset values and timing counts.
  Assumes a 100 MHz block clock.
*/
package usb_evt_pkg;
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned SUSPEND_TIME_US = 3000;
  localparam int unsigned RESUME_TIME_US  = 5000;
  localparam int unsigned SUSPEND_CYCLES  = SUSPEND_TIME_US * CLK_MHZ;
  localparam int unsigned RESUME_CYCLES   = RESUME_TIME_US * CLK_MHZ;
  localparam int unsigned NUM_EP          = 7;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DFLAGS   = 8'h04;
  localparam logic [7:0] OFS_DEN      = 8'h08;
  localparam logic [7:0] OFS_ADDR     = 8'h0C;
  localparam logic [7:0] OFS_FRAME_HI = 8'h10;
  localparam logic [7:0] OFS_FRAME_LO = 8'h14;
  localparam logic [7:0] OFS_EP_SEL   = 8'h18;
  localparam logic [7:0] OFS_EP_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_EP_EN    = 8'h20;

  // Control register bits
  localparam int unsigned CTRL_DETACH      = 0;
  localparam int unsigned CTRL_REMOTE_WAKE = 1;
  localparam int unsigned CTRL_LOW_SPEED   = 2;
  localparam int unsigned CTRL_CPU_RESET   = 3;
  localparam logic [7:0]  CTRL_RESET       = 8'h01;

  // Device flag and enable bits
  localparam int unsigned DF_SUSP   = 0;
  localparam int unsigned DF_SOF    = 2;
  localparam int unsigned DF_EORST  = 3;
  localparam int unsigned DF_WAKE   = 4;
  localparam int unsigned DF_EORSM  = 5;
  localparam int unsigned DF_UPRSM  = 6;
  localparam logic [7:0]  DF_MASK   = 8'h7D;
  localparam logic [7:0]  DEN_RESET = 8'h08;

  localparam int unsigned ADDR_ACT      = 7;
  localparam int unsigned FRAME_CRC_BIT = 4;

  // Endpoint flag bits
  localparam int unsigned EF_TXIN   = 0;
  localparam int unsigned EF_STALL  = 1;
  localparam int unsigned EF_RXOUT  = 2;
  localparam int unsigned EF_RXSTP  = 3;
  localparam int unsigned EF_NAKOUT = 4;
  localparam int unsigned EF_UNDER  = 5;
  localparam int unsigned EF_OVER   = 6;
  localparam int unsigned EF_NAKIN  = 7;
endpackage

// [verif/usb_evt_assertions.sv]
/*
  Port checker for usb_device_event_flags.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module usb_evt_checker #(
  parameter int unsigned N_EP          = 7,
  parameter int unsigned RESUME_CYCLES = 20
) (
  input wire logic            clk_i,
  input wire logic            rst_n_i,
  input wire logic            read_i,
  input wire logic            write_i,
  input wire logic            waitrequest_o,
  input wire logic            bus_reset_end_i,
  input wire logic [N_EP-1:0] ep_iso_i,
  input wire logic [N_EP-1:0] out_banks_full_i,
  input wire logic [N_EP-1:0] out_too_long_i,
  input wire logic [N_EP-1:0] out_drop_o,
  input wire logic [N_EP-1:0] out_truncate_o,
  input wire logic            cpu_reset_o,
  input wire logic            dp_pullup_o,
  input wire logic            dm_pullup_o,
  input wire logic            resume_drive_o
);
  logic [31:0] run_reg;
  logic [31:0] run_next;

  // Length of the current resume drive, checked against the set count on its fall
  always_comb run_next = resume_drive_o ? run_reg + 32'h1 : 32'h0;
  always_ff @(posedge clk_i) begin
    run_reg <= rst_n_i ? run_next : 32'h0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  cpu_rst_cause_a: assert property (cpu_reset_o |-> $past(bus_reset_end_i))
    else $error("cpu reset without bus reset end");
  pullup_excl_a: assert property (!(dp_pullup_o && dm_pullup_o))
    else $error("both pull-ups on");
  drop_iso_a: assert property (out_drop_o == $past(out_banks_full_i & ep_iso_i))
    else $error("drop pulse does not follow full iso banks");
  trunc_long_a: assert property (out_truncate_o == $past(out_too_long_i))
    else $error("truncate pulse does not follow oversized packet");
  wait_answer_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("no answer one cycle after request");
  wait_release_a: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  resume_len_a: assert property ($fell(resume_drive_o) |-> run_reg == RESUME_CYCLES)
    else $error("resume drive length wrong");
  resume_cause_a: assert property ($rose(resume_drive_o) |-> $past(write_i) || $past(write_i, 2))
    else $error("resume drive without register write");
endmodule

bind usb_device_event_flags usb_evt_checker #(
  .N_EP(N_EP),
  .RESUME_CYCLES(RESUME_CYCLES)
) chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .read_i(read_i), .write_i(write_i),
  .waitrequest_o(waitrequest_o), .bus_reset_end_i(bus_reset_end_i), .ep_iso_i(ep_iso_i),
  .out_banks_full_i(out_banks_full_i), .out_too_long_i(out_too_long_i),
  .out_drop_o(out_drop_o), .out_truncate_o(out_truncate_o), .cpu_reset_o(cpu_reset_o),
  .dp_pullup_o(dp_pullup_o), .dm_pullup_o(dm_pullup_o), .resume_drive_o(resume_drive_o)
);

// [verif/usb_host_model.sv]
/*
  Behavioural USB host as seen through the link-side event ports.
  Assumes the block clock; rows 0-9 are endpoint events, 10 frame start,
  11 bus reset end, 12 host resume end.
*/
`timescale 1ns/1ps
module usb_host_model #(
  parameter int unsigned N_EP = 7
) (
  input  wire logic             clk_i,
  output logic [12:0][N_EP-1:0] ev_o,
  output logic                  sof_crc_bad_o,
  output logic [10:0]           sof_frame_o,
  output logic                  bus_idle_o,
  output logic                  line_active_o
);
  initial begin
    ev_o = '0;
    sof_crc_bad_o = 1'b0;
    sof_frame_o = 11'h000;
    bus_idle_o = 1'b0;
    line_active_o = 1'b0;
  end

  // One-cycle event on the given row
  task automatic pulse(input int k, input logic [N_EP-1:0] m);
    @(posedge clk_i);
    ev_o[k] <= m;
    @(posedge clk_i);
    ev_o[k] <= '0;
  endtask

  // Frame fields mean nothing outside the pulse, so they are inverted after it
  task automatic sof(input logic [10:0] f, input logic bad);
    @(posedge clk_i);
    ev_o[10][0] <= 1'b1;
    sof_frame_o <= f;
    sof_crc_bad_o <= bad;
    @(posedge clk_i);
    ev_o[10][0] <= 1'b0;
    sof_frame_o <= ~f;
    sof_crc_bad_o <= ~bad;
  endtask

  task automatic lines(input logic idle, input logic act);
    @(posedge clk_i);
    bus_idle_o <= idle;
    line_active_o <= act;
  endtask
endmodule

// [verif/test_usb_device_event_flags.sv]
/*
  Self-checking bench for usb_device_event_flags over Avalon-MM.
  Assumes usb_host_model for link events and shortened timing counts.
*/
`timescale 1ns/1ps
module test_usb_device_event_flags;
  import usb_evt_pkg::*;
  localparam int unsigned SUSP = 50;
  localparam int unsigned RES  = 20;
  // Expected endpoint flags per event row
  localparam logic [7:0] EP_EXP [10] = '{8'h20, 8'h20, 8'h06, 8'h44, 8'h04,
                                         8'h08, 8'h01, 8'h02, 8'h80, 8'h10};
  logic             clk_i = 1'b0;
  logic             rst_n_i;
  logic [7:0]       address_i;
  logic             read_i;
  logic             write_i;
  logic [31:0]      writedata_i;
  logic [31:0]      readdata_o;
  logic             waitrequest_o;
  logic             usb_enable_i;
  logic [6:0]       ep_iso_i;
  logic [12:0][6:0] ev;
  logic             crc_bad, idle, act, clk_run;
  logic             usb_irq_o, cpu_reset_o, dp_pullup_o, dm_pullup_o, resume_drive_o;
  logic [6:0]       endpoint_irq_o, out_drop_o, out_truncate_o, device_addr_value_o;
  logic             address_activate_o;
  logic [10:0]      frame;
  logic [7:0]       rd;
  logic             rst_seen = 1'b0, drop_seen = 1'b0, trunc_seen = 1'b0;
  int               error_cnt = 0, samples_checked = 0;

  always #5 clk_i = ~clk_i;

  usb_host_model #(.N_EP(7)) host (.clk_i(clk_i), .ev_o(ev), .sof_crc_bad_o(crc_bad),
    .sof_frame_o(frame), .bus_idle_o(idle), .line_active_o(act));

  usb_device_event_flags #(.N_EP(7), .SUSPEND_CYCLES(SUSP), .RESUME_CYCLES(RES)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .usb_enable_i(usb_enable_i),
    .usb_clk_run_i(clk_run), .sof_det_i(ev[10][0]), .sof_crc_bad_i(crc_bad),
    .sof_frame_i(frame), .bus_reset_end_i(ev[11][0]), .host_resume_end_i(ev[12][0]),
    .ep_iso_i(ep_iso_i), .in_empty_read_i(ev[0]), .out_banks_full_i(ev[1]),
    .out_crc_bad_i(ev[2]), .out_too_long_i(ev[3]), .out_rx_i(ev[4]), .setup_rx_i(ev[5]),
    .in_ready_i(ev[6]), .stall_sent_i(ev[7]), .nak_in_i(ev[8]), .nak_out_i(ev[9]),
    .bus_idle_i(idle), .line_active_i(act), .usb_irq_o(usb_irq_o),
    .endpoint_irq_o(endpoint_irq_o), .out_drop_o(out_drop_o), .out_truncate_o(out_truncate_o),
    .cpu_reset_o(cpu_reset_o), .dp_pullup_o(dp_pullup_o), .dm_pullup_o(dm_pullup_o),
    .resume_drive_o(resume_drive_o), .device_addr_value_o(device_addr_value_o),
    .address_activate_o(address_activate_o));

  // Pulses are too short for the bus-paced checks, so they are latched here
  always @(posedge clk_i) begin
    if (cpu_reset_o === 1'b1) rst_seen <= 1'b1;
    if (out_drop_o[1] === 1'b1) drop_seen <= 1'b1;
    if (out_truncate_o[1] === 1'b1) trunc_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= {24'h000000, d};
    write_i <= wr;
    read_i <= ~wr;
    @(posedge clk_i);
    while (waitrequest_o !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) error_cnt++;
    rd = readdata_o[7:0];
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk({24'h000000, rd}, {24'h000000, e});
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    address_i = 8'h00;
    read_i = 1'b0;
    write_i = 1'b0;
    writedata_i = 32'h00000000;
    usb_enable_i = 1'b1;
    clk_run = 1'b1;
    ep_iso_i = 7'h02;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(OFS_CTRL, CTRL_RESET);
    rd_chk(OFS_DEN, DEN_RESET);
    rd_chk(OFS_DFLAGS, 8'h00);
    rd_chk(8'h40, 8'h00);
    wr(OFS_CTRL, 8'h00);
    settle;
    chk({30'h0, dp_pullup_o, dm_pullup_o}, 32'h2);
    wr(OFS_CTRL, 8'h04);
    settle;
    chk({30'h0, dp_pullup_o, dm_pullup_o}, 32'h1);
    wr(OFS_CTRL, 8'h05);
    settle;
    chk({30'h0, dp_pullup_o, dm_pullup_o}, 32'h0);
    wr(OFS_CTRL, 8'h02);
    rd_chk(OFS_CTRL, 8'h00);
    host.sof(11'h5A3, 1'b1);
    rd_chk(OFS_DFLAGS, 8'h04);
    chk({31'h0, usb_irq_o}, 32'h0);
    rd_chk(OFS_FRAME_HI, 8'h15);
    rd_chk(OFS_FRAME_LO, 8'hA3);
    wr(OFS_DEN, 8'h0C);
    settle;
    chk({31'h0, usb_irq_o}, 32'h1);
    wr(OFS_DFLAGS, 8'hFF);
    rd_chk(OFS_DFLAGS, 8'h04);
    wr(OFS_DFLAGS, 8'hFB);
    settle;
    chk({31'h0, usb_irq_o}, 32'h0);
    wr(OFS_ADDR, 8'h85);
    settle;
    chk({24'h0, address_activate_o, device_addr_value_o}, 32'h85);
    wr(OFS_ADDR, 8'h05);
    rd_chk(OFS_ADDR, 8'h85);
    wr(OFS_CTRL, 8'h08);
    host.pulse(11, 7'h01);
    settle;
    chk({31'h0, rst_seen}, 32'h1);
    chk({31'h0, usb_irq_o}, 32'h1);
    rd_chk(OFS_DFLAGS, 8'h08);
    rd_chk(OFS_CTRL, 8'h08);
    rd_chk(OFS_ADDR, 8'h05);
    wr(OFS_DFLAGS, 8'h00);
    usb_enable_i <= 1'b0;
    settle;
    usb_enable_i <= 1'b1;
    rd_chk(OFS_CTRL, 8'h00);
    host.lines(1'b1, 1'b0);
    repeat (SUSP + 10) @(posedge clk_i);
    rd_chk(OFS_DFLAGS, 8'h01);
    host.lines(1'b1, 1'b1);
    settle;
    rd_chk(OFS_DFLAGS, 8'h11);
    host.lines(1'b1, 1'b0);
    wr(OFS_CTRL, 8'h02);
    settle;
    chk({31'h0, resume_drive_o}, 32'h1);
    wr(OFS_CTRL, 8'h00);
    rd_chk(OFS_CTRL, 8'h02);
    rd_chk(OFS_DFLAGS, 8'h51);
    clk_run <= 1'b0;
    wr(OFS_DFLAGS, 8'h00);
    rd_chk(OFS_DFLAGS, 8'h50);
    clk_run <= 1'b1;
    repeat (RES + 10) @(posedge clk_i);
    chk({31'h0, resume_drive_o}, 32'h0);
    rd_chk(OFS_CTRL, 8'h00);
    wr(OFS_DFLAGS, 8'h00);
    rd_chk(OFS_DFLAGS, 8'h00);
    host.lines(1'b0, 1'b0);
    host.pulse(12, 7'h01);
    rd_chk(OFS_DFLAGS, 8'h20);
    wr(OFS_EP_SEL, 8'h01);
    wr(OFS_EP_EN, 8'hFF);
    for (int k = 0; k < 10; k++) begin
      host.pulse(k, 7'h02);
      settle;
      chk({31'h0, endpoint_irq_o[1]}, 32'h1);
      rd_chk(OFS_EP_FLAGS, EP_EXP[k]);
      wr(OFS_EP_FLAGS, 8'hFF);
      rd_chk(OFS_EP_FLAGS, EP_EXP[k]);
      wr(OFS_EP_FLAGS, 8'h00);
      rd_chk(OFS_EP_FLAGS, 8'h00);
    end
    wr(OFS_EP_SEL, 8'h00);
    host.pulse(0, 7'h01);
    rd_chk(OFS_EP_FLAGS, 8'h00);
    host.pulse(3, 7'h01);
    rd_chk(OFS_EP_FLAGS, 8'h44);
    chk({31'h0, drop_seen}, 32'h1);
    chk({31'h0, trunc_seen}, 32'h1);
    complete_run;
  end

  // Whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    complete_run;
  end
endmodule
